// File: verilog/tpg_cfg.svh
// Constants of the twelve-bit pulse generator: offsets, fields, resets and timing.
// Function
// (R01) Each generator has a 12-bit up-counter.
// (R02) Count clock is 2, 4, 16 or 256 instruction cycles.
// (R03) Period and high width stored independently.
// (R04) Usable periods span 2 to 4095 count clocks.
// (R05) Output high from restart until high-width match.
// (R06) Then low until cycle match, counter restarts.
// (R07) High width not below cycle keeps output high.
// (R08) Zero high width gives steady low output.
// (R09) Period equals cycle value times count clock.
// (R10) High time equals high width times count clock.
// (R11) Clearing output enable resets the counter.
// (R12) Duty equals high width over cycle value.
// (R13) Two independent generators, each with own pin.
// (R14) Control and first reload hold clock, width.
// (R15) Second and third reload hold enable, cycle.
// (R16) Width low six in control, upper in reload.
// (R17) Enable starts output and counting; clear stops.
// (R18) Counting starts from zero with output high.
// (R19) Software programs values before setting enable.
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

// ----------------------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define TPG_IDX_B_CONTROL 8'h38
`define TPG_IDX_B_ENABLE_CYCLE_LOW 8'h39
`define TPG_IDX_B_HIGH_WIDTH_UPPER 8'h3a
`define TPG_IDX_B_CYCLE_UPPER 8'h3b
`define TPG_IDX_A_CONTROL 8'h4c
`define TPG_IDX_A_ENABLE_CYCLE_LOW 8'h4d
`define TPG_IDX_A_HIGH_WIDTH_UPPER 8'h4e
`define TPG_IDX_A_CYCLE_UPPER 8'h4f
`define TPG_IDX_A_COUNT_LOW 8'h50
`define TPG_IDX_A_COUNT_UPPER 8'h51
`define TPG_IDX_B_COUNT_LOW 8'h52
`define TPG_IDX_B_COUNT_UPPER 8'h53

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define TPG_CLK_SEL_MSB 7
`define TPG_CLK_SEL_LSB 6
`define TPG_FIELD_MSB 5
`define TPG_ENABLE_BIT 7
`define TPG_COUNT_FLAG_BIT 7

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define TPG_RST_CONTROL 8'h00
`define TPG_RST_FIELD6 6'h00
`define TPG_RST_ENABLE 1'b0

// ----------------------------------------------------------------------------
// Timing: count clock periods in instruction cycles.
// ----------------------------------------------------------------------------
`define TPG_INST_DIV_DEFAULT 4
`define TPG_PRESCALE_W 8
`define TPG_MASK_2 8'h01
`define TPG_MASK_4 8'h03
`define TPG_MASK_16 8'h0f
`define TPG_MASK_256 8'hff

`endif

// File: verilog/tpg_pkg.sv
// Types shared by the twelve-bit pulse generator modules.
`default_nettype none

package tpg_pkg;
   typedef logic [11:0] tpg_count_t;
   typedef logic [7:0] tpg_byte_t;
   typedef enum logic [1:0] {
      TPG_CLK_2,
      TPG_CLK_4,
      TPG_CLK_16,
      TPG_CLK_256
   } tpg_clk_sel_e;
   typedef enum logic [2:0] {
      TPG_REG_CONTROL,
      TPG_REG_HIGH_UPPER,
      TPG_REG_ENABLE_CYCLE_LOW,
      TPG_REG_CYCLE_UPPER,
      TPG_REG_COUNT_LOW,
      TPG_REG_COUNT_UPPER,
      TPG_REG_NONE
   } tpg_reg_kind_e;
endpackage

`default_nettype wire

// File: verilog/tpg_gen_if.sv
// Connection between the register file and one generator core.
`default_nettype none

interface tpg_gen_if;
   import tpg_pkg::*;
   logic enable;
   logic tick;
   tpg_count_t high_width;
   tpg_count_t cycle;
   tpg_count_t count;
   logic pulse;
   modport ctl (output enable, output tick, output high_width, output cycle,
                input count, input pulse);
   modport gen (input enable, input tick, input high_width, input cycle,
                output count, output pulse);
endinterface

`default_nettype wire

// File: verilog/tpg_gen.sv
// One pulse generator core: counter, comparators and output flop.
`default_nettype none

module tpg_gen (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Settings and results.
   tpg_gen_if.gen gif
);
   import tpg_pkg::*;

   tpg_count_t count_ff;
   tpg_count_t nxt_count;
   logic pulse_ff;
   logic nxt_pulse;

   function automatic logic level_at(input tpg_count_t cnt, input tpg_count_t hw,
                                     input tpg_count_t cyc);
      if (hw == 12'h000) begin
         level_at = 1'b0; // R08
      end else if (hw >= cyc) begin
         level_at = 1'b1; // R07
      end else begin
         level_at = (cnt < hw); // R05 R10 R12
      end
   endfunction

   always_comb begin
      nxt_count = count_ff;
      if (!gif.enable) begin
         nxt_count = 12'h000; // R11 R17
      end else if (gif.tick) begin
         if (count_ff == gif.cycle - 12'h001) begin
            nxt_count = 12'h000; // R06 R09 R04
         end else begin
            nxt_count = count_ff + 12'h001; // R01
         end
      end
   end

   always_comb begin
      nxt_pulse = gif.enable && level_at(nxt_count, gif.high_width, gif.cycle); // R18
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_ff <= 12'h000;
      end else begin
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end

   assign gif.count = count_ff;
   assign gif.pulse = pulse_ff;
endmodule

`default_nettype wire

// File: verilog/tpg_top.sv
// Two-channel twelve-bit pulse generator with a classic Wishbone register slave.
`include "tpg_cfg.svh"
`default_nettype none

module tpg_top #(
   parameter int INST_DIV = `TPG_INST_DIV_DEFAULT,
   parameter int NUM_GEN = 2
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pulse pins.
   output logic pulse_out_a_o,
   output logic pulse_out_b_o,
   output logic pulse_en_a_o,
   output logic pulse_en_b_o
);
   import tpg_pkg::*;

   // -------------------------------------------------------------------------
   // Instruction cycle and count clock prescaler.
   // -------------------------------------------------------------------------
   localparam int INST_W = (INST_DIV > 1) ? $clog2(INST_DIV) : 1;
   localparam logic [INST_W-1:0] INST_LAST = INST_W'(INST_DIV - 1);

   logic [INST_W-1:0] inst_cnt_ff;
   logic inst_tick;
   logic [`TPG_PRESCALE_W-1:0] pre_cnt_ff;

   assign inst_tick = (inst_cnt_ff == INST_LAST);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         inst_cnt_ff <= '0;
      end else if (inst_tick) begin
         inst_cnt_ff <= '0;
      end else begin
         inst_cnt_ff <= inst_cnt_ff + INST_W'(1);
      end
   end

   // The prescaler runs free, so a start is not aligned with the count clock.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_cnt_ff <= '0;
      end else if (inst_tick) begin
         pre_cnt_ff <= pre_cnt_ff + `TPG_PRESCALE_W'(1);
      end
   end

   // Returns the prescaler bits that must all be one for a count clock edge.
   function automatic logic [`TPG_PRESCALE_W-1:0] sel_mask(input tpg_clk_sel_e sel);
      logic [`TPG_PRESCALE_W-1:0] m;
      m = `TPG_MASK_2;
      unique case (sel)
         TPG_CLK_2: m = `TPG_MASK_2;
         TPG_CLK_4: m = `TPG_MASK_4;
         TPG_CLK_16: m = `TPG_MASK_16;
         TPG_CLK_256: m = `TPG_MASK_256;
      endcase
      return m;
   endfunction

   // -------------------------------------------------------------------------
   // Address decode.
   // -------------------------------------------------------------------------
   logic [7:0] reg_idx;
   logic word_ok;

   assign reg_idx = wb_adr_i[9:2];
   assign word_ok = (wb_adr_i[1:0] == 2'b00);

   // Maps a register index to the generator it belongs to.
   function automatic logic idx_gen(input logic [7:0] idx);
      unique case (idx)
         `TPG_IDX_B_CONTROL, `TPG_IDX_B_ENABLE_CYCLE_LOW,
         `TPG_IDX_B_HIGH_WIDTH_UPPER, `TPG_IDX_B_CYCLE_UPPER,
         `TPG_IDX_B_COUNT_LOW, `TPG_IDX_B_COUNT_UPPER: idx_gen = 1'b1;
         default: idx_gen = 1'b0;
      endcase
   endfunction

   // Maps a register index to the kind of register it selects.
   function automatic tpg_reg_kind_e idx_kind(input logic [7:0] idx);
      unique case (idx)
         `TPG_IDX_A_CONTROL, `TPG_IDX_B_CONTROL: idx_kind = TPG_REG_CONTROL;
         `TPG_IDX_A_HIGH_WIDTH_UPPER, `TPG_IDX_B_HIGH_WIDTH_UPPER: begin
            idx_kind = TPG_REG_HIGH_UPPER;
         end
         `TPG_IDX_A_ENABLE_CYCLE_LOW, `TPG_IDX_B_ENABLE_CYCLE_LOW: begin
            idx_kind = TPG_REG_ENABLE_CYCLE_LOW;
         end
         `TPG_IDX_A_CYCLE_UPPER, `TPG_IDX_B_CYCLE_UPPER: idx_kind = TPG_REG_CYCLE_UPPER;
         `TPG_IDX_A_COUNT_LOW, `TPG_IDX_B_COUNT_LOW: idx_kind = TPG_REG_COUNT_LOW;
         `TPG_IDX_A_COUNT_UPPER, `TPG_IDX_B_COUNT_UPPER: idx_kind = TPG_REG_COUNT_UPPER;
         default: idx_kind = TPG_REG_NONE;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // Bus handshake.
   // -------------------------------------------------------------------------
   logic req;
   logic ack_ff;
   logic wr_go;
   logic acc_gen;
   tpg_reg_kind_e acc_kind;

   assign req = wb_cyc_i && wb_stb_i;
   assign acc_gen = idx_gen(reg_idx);
   assign acc_kind = word_ok ? idx_kind(reg_idx) : TPG_REG_NONE;
   // Writes take effect at the edge that raises ack, once per request.
   assign wr_go = req && wb_we_i && !ack_ff && wb_sel_i[0];

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   assign wb_ack_o = ack_ff;

   // -------------------------------------------------------------------------
   // Generators and their registers.
   // -------------------------------------------------------------------------
   logic [7:0] control_ff [NUM_GEN];
   logic [5:0] high_upper_ff [NUM_GEN];
   logic enable_ff [NUM_GEN];
   logic [5:0] cycle_low_ff [NUM_GEN];
   logic [5:0] cycle_upper_ff [NUM_GEN];
   tpg_count_t gen_count [NUM_GEN];
   logic gen_pulse [NUM_GEN];
   logic [7:0] rd_byte [NUM_GEN];

   genvar g;
   generate
      for (g = 0; g < NUM_GEN; g++) begin : gen_ch
         tpg_gen_if gif ();
         logic hit;
         tpg_clk_sel_e sel;

         assign hit = wr_go && (int'(acc_gen) == g);
         assign sel = tpg_clk_sel_e'(control_ff[g][`TPG_CLK_SEL_MSB:`TPG_CLK_SEL_LSB]);

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               control_ff[g] <= `TPG_RST_CONTROL;
            end else if (hit && acc_kind == TPG_REG_CONTROL) begin
               control_ff[g] <= wb_dat_i[7:0]; // R14 R02
            end
         end

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               high_upper_ff[g] <= `TPG_RST_FIELD6;
            end else if (hit && acc_kind == TPG_REG_HIGH_UPPER) begin
               high_upper_ff[g] <= wb_dat_i[`TPG_FIELD_MSB:0]; // R14 R03
            end
         end

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               enable_ff[g] <= `TPG_RST_ENABLE;
               cycle_low_ff[g] <= `TPG_RST_FIELD6;
            end else if (hit && acc_kind == TPG_REG_ENABLE_CYCLE_LOW) begin
               enable_ff[g] <= wb_dat_i[`TPG_ENABLE_BIT]; // R15 R17
               cycle_low_ff[g] <= wb_dat_i[`TPG_FIELD_MSB:0]; // R15 R03
            end
         end

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               cycle_upper_ff[g] <= `TPG_RST_FIELD6;
            end else if (hit && acc_kind == TPG_REG_CYCLE_UPPER) begin
               cycle_upper_ff[g] <= wb_dat_i[`TPG_FIELD_MSB:0]; // R15
            end
         end

         assign gif.enable = enable_ff[g];
         assign gif.tick = inst_tick && ((pre_cnt_ff & sel_mask(sel)) == sel_mask(sel)); // R02
         assign gif.high_width = {high_upper_ff[g], control_ff[g][`TPG_FIELD_MSB:0]}; // R16
         assign gif.cycle = {cycle_upper_ff[g], cycle_low_ff[g]}; // R04
         assign gen_count[g] = gif.count;
         assign gen_pulse[g] = gif.pulse;

         tpg_gen u_gen (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .gif(gif.gen)
         );

         // Read view of this generator; the unused enable-register bit reads zero.
         always_comb begin
            rd_byte[g] = 8'h00;
            unique case (acc_kind)
               TPG_REG_CONTROL: rd_byte[g] = control_ff[g];
               TPG_REG_HIGH_UPPER: rd_byte[g] = {2'b00, high_upper_ff[g]};
               TPG_REG_ENABLE_CYCLE_LOW: rd_byte[g] = {enable_ff[g], 1'b0, cycle_low_ff[g]};
               TPG_REG_CYCLE_UPPER: rd_byte[g] = {2'b00, cycle_upper_ff[g]};
               TPG_REG_COUNT_LOW: rd_byte[g] = {2'b00, gen_count[g][5:0]};
               TPG_REG_COUNT_UPPER: rd_byte[g] = {gen_pulse[g], 1'b0, gen_count[g][11:6]};
               TPG_REG_NONE: rd_byte[g] = 8'h00;
            endcase
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Read data.
   // -------------------------------------------------------------------------
   logic [31:0] rd_data_ff;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_data_ff <= 32'h0000_0000;
      end else if (req && !ack_ff) begin
         rd_data_ff <= {24'h00_0000, rd_byte[acc_gen]};
      end
   end

   assign wb_dat_o = rd_data_ff;

   // -------------------------------------------------------------------------
   // Pins: generator A is index 0, generator B index 1.
   // -------------------------------------------------------------------------
   assign pulse_out_a_o = gen_pulse[0]; // R13
   assign pulse_out_b_o = gen_pulse[1]; // R13
   assign pulse_en_a_o = enable_ff[0]; // R17
   assign pulse_en_b_o = enable_ff[1]; // R17
endmodule

`default_nettype wire

// File: tb/tpg_load.sv
// Load on one pulse pin that measures period and high time in clocks.
`default_nettype none

module tpg_load (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Pin and measurements.
   input wire logic pin_i,
   output int high_o,
   output int period_o,
   output int rises_o
);
   logic last_ff;
   int run_ff;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_ff <= 1'b0;
         run_ff <= 0;
         high_o <= 0;
         period_o <= 0;
         rises_o <= 0;
      end else begin
         last_ff <= pin_i;
         run_ff <= run_ff + 1;
         if (pin_i && !last_ff) begin
            period_o <= run_ff;
            run_ff <= 1;
            rises_o <= rises_o + 1;
         end
         if (!pin_i && last_ff) begin
            high_o <= run_ff;
         end
      end
   end
endmodule

`default_nettype wire

// File: tb/tpg_top_properties.sv
// Checker of the bus answers and pin levels of the pulse generator.
`default_nettype none

module tpg_top_properties (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Bus.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins.
   input wire logic pulse_out_a_o,
   input wire logic pulse_out_b_o,
   input wire logic pulse_en_a_o,
   input wire logic pulse_en_b_o
);
   logic rd_ack;
   logic mapped;
   assign rd_ack = wb_ack_o && wb_cyc_i && !wb_we_i;
   assign mapped = wb_adr_i[1:0] == 2'b00 &&
      (wb_adr_i[9:2] inside {[8'h38:8'h3b], [8'h4c:8'h53]});
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   ack_needs_request_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   read_upper_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   unmapped_reads_zero_a: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   enable_readback_a: assert property (
      rd_ack && wb_adr_i[9:2] == 8'h4d |-> wb_dat_o[7:6] == {pulse_en_a_o, 1'b0})
      else $error("channel a enable readback wrong");
   enable_b_readback_a: assert property (
      rd_ack && wb_adr_i[9:2] == 8'h39 |-> wb_dat_o[7:6] == {pulse_en_b_o, 1'b0})
      else $error("channel b enable readback wrong");
   stop_a_low_a: assert property (!pulse_en_a_o |=> !pulse_out_a_o)
      else $error("channel a drives high while disabled");
   stop_b_low_a: assert property (!pulse_en_b_o |=> !pulse_out_b_o)
      else $error("channel b drives high while disabled");
   write_seen_c: cover property (wb_ack_o && wb_we_i);
   pulse_a_rise_c: cover property ($rose(pulse_out_a_o));
   pulse_b_rise_c: cover property ($rose(pulse_out_b_o));
endmodule

bind tpg_top tpg_top_properties i_tpg_top_properties (.clk_i(clk_i), .nrst_i(nrst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_out_a_o(pulse_out_a_o),
   .pulse_out_b_o(pulse_out_b_o), .pulse_en_a_o(pulse_en_a_o), .pulse_en_b_o(pulse_en_b_o));

`default_nettype wire

// File: tb/test_tpg_top.sv
// Self-checking bench of the two-channel pulse generator.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module test_tpg_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i, nrst_i, cyc, stb, we, ack, pa, pb, ea, eb;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, rdat;
   int ha, pra, ra, hb, prb, rb;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int dv[4] = '{2, 4, 16, 256};
   tpg_top #(.INST_DIV(1), .NUM_GEN(2)) i_tpg_top (.clk_i(clk_i), .nrst_i(nrst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pulse_out_a_o(pa),
      .pulse_out_b_o(pb), .pulse_en_a_o(ea), .pulse_en_b_o(eb));
   tpg_load i_tpg_load_a (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pa), .high_o(ha),
      .period_o(pra), .rises_o(ra));
   tpg_load i_tpg_load_b (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pb), .high_o(hb),
      .period_o(prb), .rises_o(rb));
   task automatic conclude;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
      input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      sel <= s;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
      xfer(1'b0, idx, 8'h00, 4'hf);
      `CHK(rdat, e)
   endtask
   // Values go in before the enable bit, so the first period is not stretched.
   task automatic prog(input logic b, input logic [1:0] s, input logic [11:0] hw,
      input logic [11:0] cy);
      logic [7:0] base;
      base = b ? 8'h38 : 8'h4c;
      xfer(1'b1, base + 8'h1, {2'b00, cy[5:0]}, 4'hf);
      xfer(1'b1, base, {s, hw[5:0]}, 4'hf);
      xfer(1'b1, base + 8'h2, {2'b00, hw[11:6]}, 4'hf);
      xfer(1'b1, base + 8'h3, {2'b00, cy[11:6]}, 4'hf);
      xfer(1'b1, base + 8'h1, {2'b10, cy[5:0]}, 4'hf);
   endtask
   task automatic t_regs;
      `CHK({pa, pb, ea, eb}, 4'h0)
      rd_chk(8'h4c, 32'h0);
      rd_chk(8'h39, 32'h0);
      xfer(1'b1, 8'h00, 8'hff, 4'hf);
      rd_chk(8'h00, 32'h0);
      xfer(1'b1, 8'h4c, 8'ha5, 4'he);
      rd_chk(8'h4c, 32'h0);
      xfer(1'b1, 8'h4c, 8'h5a, 4'hf);
      rd_chk(8'h4c, 32'h5a);
   endtask
   task automatic t_wave;
      logic [11:0] hws[4] = '{12'h001, 12'h003, 12'h002, 12'h001};
      logic [11:0] cys[4] = '{12'h002, 12'h005, 12'h007, 12'h003};
      int r0;
      prog(1'b1, 2'd0, 12'h041, 12'h043);
      for (int i = 0; i < 4; i++) begin
         prog(1'b0, 2'(i), hws[i], cys[i]);
         r0 = ra;
         while (ra < r0 + 3) @(posedge clk_i);
         `CHK(pra, int'(cys[i]) * dv[i])
         `CHK(ha, int'(hws[i]) * dv[i])
      end
      r0 = rb;
      while (rb < r0 + 2) @(posedge clk_i);
      `CHK(prb, 134)
      `CHK(hb, 130)
      rd_chk(8'h39, 32'h83);
      rd_chk(8'h3a, 32'h01);
      rd_chk(8'h3b, 32'h01);
   endtask
   task automatic t_steady;
      logic [11:0] hws[3] = '{12'h000, 12'h004, 12'h006};
      int r0;
      for (int i = 0; i < 3; i++) begin
         prog(1'b0, 2'd0, hws[i], 12'h004);
         repeat (20) @(posedge clk_i);
         r0 = ra;
         repeat (40) @(posedge clk_i);
         `CHK(pa, i != 0)
         `CHK(ra, r0)
      end
   endtask
   task automatic t_stop;
      prog(1'b0, 2'd0, 12'h002, 12'h005);
      repeat (13) @(posedge clk_i);
      rd_chk(8'h4d, 32'h85);
      xfer(1'b1, 8'h4d, 8'h05, 4'hf);
      repeat (2) @(posedge clk_i);
      `CHK({pa, ea}, 2'b00)
      rd_chk(8'h50, 32'h0);
      rd_chk(8'h51, 32'h0);
      xfer(1'b1, 8'h4d, 8'h85, 4'hf);
      repeat (2) @(posedge clk_i);
      `CHK({pa, ea}, 2'b11)
   endtask
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      nrst_i = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      wdat = 32'h0;
      sel = 4'hf;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_regs;
      t_wave;
      t_steady;
      t_stop;
      conclude;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude;
      end
   end
endmodule

`default_nettype wire
